/* File: rtl/dcd_defs.svh */
// Function
// - Run source code 0 keypad, 1 terminals, 2 serial, 3 none, 5 comm card.
// - Standard hand-off-auto with both terminal functions 41 and 42 off blocks run and jog.
// - Hand/auto switching needs a terminal with function 41, 42, 56 or the keypad option.
// - Keypad run source disables switching between hand and automatic modes.
// - Stop method 0 ramps down at deceleration rate to minimum, then stops.
// - Stop method 1 cuts output at once and lets the motor coast.
// - Keypad frequency source: undervoltage or fault latches the frequency command.
// - Display format bits 0 to 3 give zero to three decimal places.
// - Display format bits 4 to 15 give the unit, 000 to 024; others mean Hz.
// - Maximum user value zero disables the user value; nonzero enables it.
// - Maximum user value is unsigned 16 bits, read with the chosen decimal places.
// - User value scales so its maximum matches the maximum operating frequency.
// - User value is valid only with keypad or serial frequency source.
`ifndef DCD_DEFS_SVH
`define DCD_DEFS_SVH

`define DCD_ADDR_RUN_SOURCE   8'h15
`define DCD_ADDR_STOP_METHOD  8'h16
`define DCD_ADDR_DIR_PERMIT   8'h17
`define DCD_ADDR_KEYPAD_MEM   8'h18
`define DCD_ADDR_DISPLAY_FMT  8'h19
`define DCD_ADDR_USER_MAX     8'h1a
`define DCD_ADDR_USER_READ    8'h1b

`define DCD_RST_RUN_SOURCE    16'h0000
`define DCD_RST_STOP_METHOD   16'h0000
`define DCD_RST_DIR_PERMIT    16'h0000
`define DCD_RST_KEYPAD_MEM    16'h0000
`define DCD_RST_DISPLAY_FMT   16'h0000
`define DCD_RST_USER_MAX      16'h0000

`define DCD_FMT_DEC_MSB       3
`define DCD_FMT_DEC_LSB       0
`define DCD_FMT_UNIT_MSB      15
`define DCD_FMT_UNIT_LSB      4
`define DCD_DEC_MAX           4'h3
`define DCD_UNIT_LAST         12'h024

`define DCD_SRC_KEYPAD        16'h0000
`define DCD_SRC_TERMINAL      16'h0001
`define DCD_SRC_SERIAL        16'h0002
`define DCD_SRC_CARD          16'h0005
`define DCD_STOP_COAST        16'h0001
`define DCD_DIR_NO_REVERSE    16'h0001
`define DCD_DIR_NO_FORWARD    16'h0002
`define DCD_FREQ_KEYPAD       4'h0
`define DCD_FREQ_SERIAL       4'h1

`define DCD_DIV_STEPS         6'h20

`endif

/* File: rtl/dcd_div_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dcd_div_if;
    logic        start;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic [31:0] quotient;
    logic        done;
    modport requester (output start, dividend, divisor, input quotient, done);
    modport divider   (input start, dividend, divisor, output quotient, done);
endinterface : dcd_div_if
`default_nettype wire

/* File: rtl/dcd_divider.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcd_defs.svh"
module dcd_divider (
    input  wire logic  core_clk,
    input  wire logic  rst,
    input  wire logic  clkEn,
    dcd_div_if.divider div
);
    dcd_pkg::dcd_div_state_type state;
    dcd_pkg::dcd_div_state_type next_state;
    logic [31:0] quot;
    logic [31:0] next_quot;
    logic [15:0] rem;
    logic [15:0] next_rem;
    logic [15:0] dvs;
    logic [15:0] next_dvs;
    logic [5:0]  step;
    logic [5:0]  next_step;
    logic        done;
    logic        next_done;
    logic [16:0] trial;

    // Restoring division, one quotient bit per cycle
    always_comb begin
        next_state = state;
        next_quot  = quot;
        next_rem   = rem;
        next_dvs   = dvs;
        next_step  = step;
        next_done  = 1'b0;
        trial      = {rem, quot[31]};
        case (state)
            dcd_pkg::DIV_IDLE: begin
                if (div.start) begin
                    next_quot  = div.dividend;
                    next_dvs   = div.divisor;
                    next_rem   = 16'h0000;
                    next_step  = 6'h00;
                    next_state = dcd_pkg::DIV_BUSY;
                end
            end
            dcd_pkg::DIV_BUSY: begin
                next_quot = {quot[30:0], 1'b0};
                if (trial >= {1'b0, dvs}) begin
                    next_rem     = 16'(trial - {1'b0, dvs});
                    next_quot[0] = 1'b1;
                end else begin
                    next_rem = trial[15:0];
                end
                next_step = 6'(step + 6'h01);
                if (next_step == `DCD_DIV_STEPS) begin
                    next_done  = 1'b1;
                    next_state = dcd_pkg::DIV_IDLE;
                end
            end
            default: next_state = dcd_pkg::DIV_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= dcd_pkg::DIV_IDLE;
            quot  <= 32'h00000000;
            rem   <= 16'h0000;
            dvs   <= 16'h0000;
            step  <= 6'h00;
            done  <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            quot  <= next_quot;
            rem   <= next_rem;
            dvs   <= next_dvs;
            step  <= next_step;
            done  <= next_done;
        end
    end

    assign div.quotient = quot;
    assign div.done     = done;
endmodule : dcd_divider
`default_nettype wire

/* File: rtl/dcd_drive_config.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_defs.svh"
module dcd_drive_config (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdData,
    input  wire logic        undervoltagePin,
    input  wire logic        terminalFunc41Pin,
    input  wire logic        terminalFunc42Pin,
    input  wire logic        terminalRunPin,
    input  wire logic        terminalReversePin,
    input  wire logic        faultEvent,
    input  wire logic        keypadRun,
    input  wire logic        keypadReverse,
    input  wire logic        serialRun,
    input  wire logic        serialReverse,
    input  wire logic        cardRun,
    input  wire logic        cardReverse,
    input  wire logic        jogRequest,
    input  wire logic        stopCommand,
    input  wire logic        motorAtRest,
    input  wire logic        hoaStandardMode,
    input  wire logic        hoaTerminalAssigned,
    input  wire logic        keypadOptionPresent,
    input  wire logic        handRequest,
    input  wire logic [3:0]  remoteFreqSource,
    input  wire logic [15:0] freqCommand,
    input  wire logic [15:0] maxOperatingFrequency,
    output logic             driveRun,
    output logic             driveReverse,
    output logic             jogActive,
    output logic             rampDown,
    output logic             outputCutoff,
    output logic             handMode,
    output logic      [1:0]  decimalPlaces,
    output logic      [5:0]  displayUnit,
    output logic             userValueEnable,
    output logic             userValueValid,
    output logic      [15:0] userValue
);
    localparam int PIN_UV  = 0;
    localparam int PIN_F41 = 1;
    localparam int PIN_F42 = 2;
    localparam int PIN_RUN = 3;
    localparam int PIN_REV = 4;

    dcd_div_if divBus ();

    // Register file
    logic [15:0] runSource;
    logic [15:0] stopMethod;
    logic [15:0] dirPermit;
    logic [15:0] keypadFreqMemory;
    logic [15:0] displayFormat;
    logic [15:0] userMax;
    logic [15:0] next_runSource;
    logic [15:0] next_stopMethod;
    logic [15:0] next_dirPermit;
    logic [15:0] next_keypadFreqMemory;
    logic [15:0] next_displayFormat;
    logic [15:0] next_userMax;
    logic [15:0] next_regRdData;

    // Pin synchronisers
    logic [4:0]  pinMeta;
    logic [4:0]  pinSync2;
    logic [4:0]  pinSync3;
    logic [4:0]  pinStable;
    logic [4:0]  next_pinStable;
    logic        uvPrev;
    logic        faultPrev;
    logic        uvRise;
    logic        faultRise;

    // Run control
    dcd_pkg::dcd_run_state_type runState;
    dcd_pkg::dcd_run_state_type next_runState;
    logic [1:0]  selCmd;
    logic        hoaBlock;
    logic        runReq;
    logic        sourceValid;
    logic        next_driveRun;
    logic        next_driveReverse;
    logic        next_jogActive;
    logic        next_rampDown;
    logic        next_outputCutoff;
    logic        next_handMode;
    logic        switchAllowed;

    // Display and user value
    logic [1:0]  next_decimalPlaces;
    logic [5:0]  next_displayUnit;
    logic        next_userValueEnable;
    logic        next_userValueValid;
    logic [15:0] next_userValue;
    logic        divBusy;
    logic        next_divBusy;
    logic        next_divStart;
    logic        divStart;

    function automatic logic [1:0] pickSource(input logic [15:0] code,
                                              input logic [3:0]  runs,
                                              input logic [3:0]  revs);
        logic [1:0] sel;
        sel = 2'h0;
        if (code == `DCD_SRC_KEYPAD) begin
            sel = {runs[0], revs[0]};
        end else if (code == `DCD_SRC_TERMINAL) begin
            sel = {runs[1], revs[1]};
        end else if (code == `DCD_SRC_SERIAL) begin
            sel = {runs[2], revs[2]};
        end else if (code == `DCD_SRC_CARD) begin
            sel = {runs[3], revs[3]};
        end
        return sel;
    endfunction : pickSource

    function automatic logic dirAllowed(input logic [15:0] permit, input logic reverse);
        return reverse ? (permit != `DCD_DIR_NO_REVERSE) : (permit != `DCD_DIR_NO_FORWARD);
    endfunction : dirAllowed

    // Three-stage capture; a change counts when stages two and three agree
    always_comb begin
        next_pinStable = pinStable;
        for (int i = 0; i < 5; i++) begin
            if (pinSync2[i] == pinSync3[i]) begin
                next_pinStable[i] = pinSync3[i];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinMeta   <= 5'h00;
            pinSync2  <= 5'h00;
            pinSync3  <= 5'h00;
            pinStable <= 5'h00;
            uvPrev    <= 1'b0;
            faultPrev <= 1'b0;
        end else if (clkEn) begin
            pinMeta   <= {terminalReversePin, terminalRunPin, terminalFunc42Pin,
                          terminalFunc41Pin, undervoltagePin};
            pinSync2  <= pinMeta;
            pinSync3  <= pinSync2;
            pinStable <= next_pinStable;
            uvPrev    <= pinStable[PIN_UV];
            faultPrev <= faultEvent;
        end
    end

    assign uvRise    = pinStable[PIN_UV] & ~uvPrev;
    assign faultRise = faultEvent & ~faultPrev;

    // Register writes, read data and the keypad frequency memory
    always_comb begin
        next_runSource        = runSource;
        next_stopMethod       = stopMethod;
        next_dirPermit        = dirPermit;
        next_displayFormat    = displayFormat;
        next_userMax          = userMax;
        next_keypadFreqMemory = keypadFreqMemory;
        next_regRdData        = 16'h0000;
        if (regWr) begin
            if (regAddr == `DCD_ADDR_RUN_SOURCE) begin
                next_runSource = regWrData;
            end else if (regAddr == `DCD_ADDR_STOP_METHOD) begin
                next_stopMethod = regWrData;
            end else if (regAddr == `DCD_ADDR_DIR_PERMIT) begin
                next_dirPermit = regWrData;
            end else if (regAddr == `DCD_ADDR_DISPLAY_FMT) begin
                next_displayFormat = regWrData;
            end else if (regAddr == `DCD_ADDR_USER_MAX) begin
                next_userMax = regWrData;
            end
        end
        if ((uvRise || faultRise) && remoteFreqSource == `DCD_FREQ_KEYPAD) begin
            next_keypadFreqMemory = freqCommand;
        end
        if (regRd) begin
            if (regAddr == `DCD_ADDR_RUN_SOURCE) begin
                next_regRdData = runSource;
            end else if (regAddr == `DCD_ADDR_STOP_METHOD) begin
                next_regRdData = stopMethod;
            end else if (regAddr == `DCD_ADDR_DIR_PERMIT) begin
                next_regRdData = dirPermit;
            end else if (regAddr == `DCD_ADDR_KEYPAD_MEM) begin
                next_regRdData = keypadFreqMemory;
            end else if (regAddr == `DCD_ADDR_DISPLAY_FMT) begin
                next_regRdData = displayFormat;
            end else if (regAddr == `DCD_ADDR_USER_MAX) begin
                next_regRdData = userMax;
            end else if (regAddr == `DCD_ADDR_USER_READ) begin
                next_regRdData = userValue;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            runSource        <= `DCD_RST_RUN_SOURCE;
            stopMethod       <= `DCD_RST_STOP_METHOD;
            dirPermit        <= `DCD_RST_DIR_PERMIT;
            keypadFreqMemory <= `DCD_RST_KEYPAD_MEM;
            displayFormat    <= `DCD_RST_DISPLAY_FMT;
            userMax          <= `DCD_RST_USER_MAX;
            regRdData        <= 16'h0000;
        end else if (clkEn) begin
            runSource        <= next_runSource;
            stopMethod       <= next_stopMethod;
            dirPermit        <= next_dirPermit;
            keypadFreqMemory <= next_keypadFreqMemory;
            displayFormat    <= next_displayFormat;
            userMax          <= next_userMax;
            regRdData        <= next_regRdData;
        end
    end

    // Run command selection and stop handling
    assign selCmd = pickSource(runSource,
                               {cardRun, serialRun, pinStable[PIN_RUN], keypadRun},
                               {cardReverse, serialReverse, pinStable[PIN_REV], keypadReverse});
    assign sourceValid = (runSource == `DCD_SRC_KEYPAD) || (runSource == `DCD_SRC_TERMINAL) ||
                         (runSource == `DCD_SRC_SERIAL) || (runSource == `DCD_SRC_CARD);
    assign hoaBlock = hoaStandardMode & ~pinStable[PIN_F41] & ~pinStable[PIN_F42];
    assign runReq   = selCmd[1] & ~hoaBlock & dirAllowed(dirPermit, selCmd[0]);
    assign switchAllowed = (hoaTerminalAssigned | keypadOptionPresent) &
                           (runSource != `DCD_SRC_KEYPAD);

    always_comb begin
        next_runState     = runState;
        next_driveReverse = driveReverse;
        next_handMode     = switchAllowed ? handRequest : handMode;
        next_jogActive    = jogRequest & sourceValid & ~hoaBlock &
                            dirAllowed(dirPermit, selCmd[0]);
        case (runState)
            dcd_pkg::RUN_IDLE: begin
                if (runReq) begin
                    next_runState     = dcd_pkg::RUN_ACTIVE;
                    next_driveReverse = selCmd[0];
                end
            end
            dcd_pkg::RUN_ACTIVE: begin
                if (stopCommand || !runReq) begin
                    if (stopMethod == `DCD_STOP_COAST) begin
                        next_runState = dcd_pkg::RUN_COAST;
                    end else begin
                        next_runState = dcd_pkg::RUN_RAMP;
                    end
                end
            end
            dcd_pkg::RUN_RAMP: begin
                if (motorAtRest) begin
                    next_runState = dcd_pkg::RUN_IDLE;
                end
            end
            dcd_pkg::RUN_COAST: begin
                if (motorAtRest) begin
                    next_runState = dcd_pkg::RUN_IDLE;
                end
            end
            default: next_runState = dcd_pkg::RUN_IDLE;
        endcase
        next_driveRun     = (next_runState == dcd_pkg::RUN_ACTIVE);
        next_rampDown     = (next_runState == dcd_pkg::RUN_RAMP);
        next_outputCutoff = (next_runState == dcd_pkg::RUN_COAST);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            runState     <= dcd_pkg::RUN_IDLE;
            driveRun     <= 1'b0;
            driveReverse <= 1'b0;
            jogActive    <= 1'b0;
            rampDown     <= 1'b0;
            outputCutoff <= 1'b0;
            handMode     <= 1'b0;
        end else if (clkEn) begin
            runState     <= next_runState;
            driveRun     <= next_driveRun;
            driveReverse <= next_driveReverse;
            jogActive    <= next_jogActive;
            rampDown     <= next_rampDown;
            outputCutoff <= next_outputCutoff;
            handMode     <= next_handMode;
        end
    end

    // Display format and scaled user value
    always_comb begin
        next_decimalPlaces = 2'h0;
        next_displayUnit   = 6'h00;
        if (displayFormat[`DCD_FMT_DEC_MSB:`DCD_FMT_DEC_LSB] <= `DCD_DEC_MAX) begin
            next_decimalPlaces = displayFormat[1:0];
        end
        if (displayFormat[`DCD_FMT_UNIT_MSB:`DCD_FMT_UNIT_LSB] <= `DCD_UNIT_LAST) begin
            next_displayUnit = displayFormat[9:4];
        end
        next_userValueEnable = (userMax != 16'h0000);
        next_userValueValid  = next_userValueEnable &&
                               (remoteFreqSource == `DCD_FREQ_KEYPAD ||
                                remoteFreqSource == `DCD_FREQ_SERIAL);
        next_divStart  = 1'b0;
        next_divBusy   = divBusy;
        next_userValue = userValue;
        if (!divBusy) begin
            next_divStart = 1'b1;
            next_divBusy  = 1'b1;
        end else if (divBusy && divBus.done) begin
            next_divBusy = 1'b0;
            if (!userValueEnable || maxOperatingFrequency == 16'h0000) begin
                next_userValue = 16'h0000;
            end else if (divBus.quotient > {16'h0000, userMax}) begin
                next_userValue = userMax;
            end else begin
                next_userValue = divBus.quotient[15:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            decimalPlaces   <= 2'h0;
            displayUnit     <= 6'h00;
            userValueEnable <= 1'b0;
            userValueValid  <= 1'b0;
            userValue       <= 16'h0000;
            divBusy         <= 1'b0;
            divStart        <= 1'b0;
        end else if (clkEn) begin
            decimalPlaces   <= next_decimalPlaces;
            displayUnit     <= next_displayUnit;
            userValueEnable <= next_userValueEnable;
            userValueValid  <= next_userValueValid;
            userValue       <= next_userValue;
            divBusy         <= next_divBusy;
            divStart        <= next_divStart;
        end
    end

    assign divBus.start    = divStart;
    assign divBus.dividend = 32'(freqCommand) * 32'(userMax);
    assign divBus.divisor  = maxOperatingFrequency;

    dcd_divider u_divider (
        .core_clk (core_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .div      (divBus)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_no_source_run;
        clkEn && !sourceValid && runState == dcd_pkg::RUN_IDLE |=> !driveRun;
    endproperty
    a_no_source_run: assert property (p_no_source_run) else $error("Run with no source");

    property p_run_start;
        clkEn && runState == dcd_pkg::RUN_IDLE && runReq |=> driveRun && !rampDown;
    endproperty
    a_run_start: assert property (p_run_start) else $error("Run not started");

    property p_hoa_jog;
        clkEn && hoaBlock |=> !jogActive;
    endproperty
    a_hoa_jog: assert property (p_hoa_jog) else $error("Jog while blocked");

    property p_keypad_lock;
        clkEn && runSource == `DCD_SRC_KEYPAD |=> handMode == $past(handMode);
    endproperty
    a_keypad_lock: assert property (p_keypad_lock) else $error("Mode switched");

    property p_coast;
        clkEn && runState == dcd_pkg::RUN_ACTIVE && stopCommand &&
        stopMethod == `DCD_STOP_COAST |=> outputCutoff && !driveRun && !rampDown;
    endproperty
    a_coast: assert property (p_coast) else $error("Coast stop missed");

    property p_ramp;
        clkEn && runState == dcd_pkg::RUN_ACTIVE && stopCommand &&
        stopMethod == 16'h0000 |=> rampDown && !outputCutoff;
    endproperty
    a_ramp: assert property (p_ramp) else $error("Ramp stop missed");

    property p_direction;
        $rose(driveRun) |-> $past(dirPermit) !=
            (driveReverse ? `DCD_DIR_NO_REVERSE : `DCD_DIR_NO_FORWARD);
    endproperty
    a_direction: assert property (p_direction) else $error("Blocked direction");

    property p_memory;
        clkEn && uvRise && remoteFreqSource == `DCD_FREQ_KEYPAD
            |=> keypadFreqMemory == $past(freqCommand);
    endproperty
    a_memory: assert property (p_memory) else $error("Memory not latched");

    property p_unit_range;
        displayUnit <= 6'h24 && decimalPlaces <= 2'h3;
    endproperty
    a_unit_range: assert property (p_unit_range) else $error("Unit out of range");

    property p_enable;
        clkEn |=> userValueEnable == ($past(userMax) != 16'h0000);
    endproperty
    a_enable: assert property (p_enable) else $error("Enable wrong");

    property p_valid;
        userValueValid && $past(clkEn) |-> userValueEnable &&
            $past(remoteFreqSource) inside {`DCD_FREQ_KEYPAD, `DCD_FREQ_SERIAL};
    endproperty
    a_valid: assert property (p_valid) else $error("Valid wrong");
endmodule : dcd_drive_config
`default_nettype wire

/* File: rtl/dcd_pkg.sv */
package dcd_pkg;
    typedef enum logic [1:0] {RUN_IDLE, RUN_ACTIVE, RUN_RAMP, RUN_COAST} dcd_run_state_type;
    typedef enum logic {DIV_IDLE, DIV_BUSY} dcd_div_state_type;
endpackage : dcd_pkg

/* File: tb/dcd_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcd_motor_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic rampDown,
    input  wire logic outputCutoff,
    output logic      motorAtRest
);
    logic [3:0] spin;
    // Motor spins down for a short or long time once rampDown or outputCutoff is set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) spin <= 4'h0;
        else if (rampDown | outputCutoff) spin <= spin + 4'h1;
        else spin <= 4'h0;
    end
    assign motorAtRest = (rampDown | outputCutoff) && spin >= (slow ? 4'h9 : 4'h1);
endmodule : dcd_motor_model
`default_nettype wire

/* File: tb/drive_command_display_config_test.sv */
`timescale 1ns/1ps
`default_nettype none
module drive_command_display_config_test;
    logic core_clk, rst, clkEn, regWr, regRd, undervoltagePin, terminalFunc41Pin, slow;
    logic terminalFunc42Pin, terminalRunPin, terminalReversePin, faultEvent, keypadRun;
    logic keypadReverse, serialRun, serialReverse, cardRun, cardReverse, jogRequest;
    logic stopCommand, motorAtRest, hoaStandardMode, hoaTerminalAssigned, jogActive;
    logic keypadOptionPresent, handRequest, driveRun, driveReverse, rampDown, handMode;
    logic outputCutoff, userValueEnable, userValueValid;
    logic [7:0]  regAddr;
    logic [15:0] regWrData, regRdData, freqCommand, maxOperatingFrequency, userValue, rdv, v;
    logic [3:0]  remoteFreqSource;
    logic [1:0]  decimalPlaces;
    logic [5:0]  displayUnit;
    integer      seed, nMismatch, checkCount, tickCount, i, j;
    dcd_drive_config DUT (.*);
    dcd_motor_model partner (.*);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a; regWrData <= d; regWr <= 1'b1;
        @(posedge core_clk) regWr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task rd(input logic [7:0] a);
        regAddr <= a; regRd <= 1'b1;
        @(posedge core_clk) regRd <= 1'b0;
        #1 rdv = regRdData;
        @(posedge core_clk);
    endtask : rd
    task runTry(input logic [15:0] c, input logic rev, input logic ok, input logic coast);
        logic vld;
        vld = c == 16'h0 || c == 16'h1 || c == 16'h2 || c == 16'h5;
        wr(8'h16, {15'h0, coast});
        wr(8'h15, c);
        keypadRun <= !vld || c == 16'h0;
        terminalRunPin <= !vld || c == 16'h1;
        serialRun <= !vld || c == 16'h2;
        cardRun <= !vld || c == 16'h5;
        {keypadReverse, terminalReversePin, serialReverse, cardReverse} <= {4{rev}};
        repeat (8) @(posedge core_clk);
        #1 chk("run", driveRun, ok);
        chk("reverse", driveReverse, ok & rev);
        chk("jog", jogActive, 1'b0);
        {keypadRun, terminalRunPin, serialRun, cardRun, stopCommand} <= 5'h01;
        repeat (4) @(posedge core_clk);
        #1 chk("ramp", rampDown, ok & !coast);
        chk("coast", outputCutoff, ok & coast);
        stopCommand <= 1'b0;
        repeat (16) @(posedge core_clk);
        #1 chk("idle", {driveRun, rampDown, outputCutoff}, 3'h0);
    endtask : runTry
    function automatic logic [1:0] places(input logic [15:0] f);
        return f[3:0] <= 4'h3 ? f[1:0] : 2'h0;
    endfunction : places
    function automatic logic [5:0] unit(input logic [15:0] f);
        return f[15:4] <= 12'h024 ? f[9:4] : 6'h0;
    endfunction : unit
    task give_verdict;
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    always @(posedge core_clk) begin
        tickCount++;
        if (tickCount == 20000) begin
            nMismatch++;
            give_verdict;
        end
    end
    initial begin
        {regWr, regRd, undervoltagePin, terminalFunc41Pin, terminalFunc42Pin} = 5'h0;
        {terminalRunPin, terminalReversePin, faultEvent, keypadRun, keypadReverse} = 5'h0;
        {serialRun, serialReverse, cardRun, cardReverse, jogRequest, stopCommand} = 6'h0;
        {hoaStandardMode, hoaTerminalAssigned, keypadOptionPresent, handRequest} = 4'h0;
        {regAddr, regWrData, freqCommand, remoteFreqSource} = 44'h0;
        maxOperatingFrequency = 16'h1770;
        {clkEn, rst, slow} = 3'h7;
        {seed, nMismatch, checkCount, tickCount} = {32'd46, 96'h0};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 8'h15; i <= 8'h1b; i++) begin
            rd(i[7:0]);
            chk("reset", rdv, 16'h0);
            v = $random(seed);
            wr(i[7:0], v);
            rd(i[7:0]);
            chk("readback", rdv, (i == 8'h18 || i == 8'h1b) ? 16'h0 : v);
        end
        rd(8'h40);
        chk("unmapped", rdv, 16'h0);
        $display("register test done");
        for (i = 0; i < 6; i++) begin
            wr(8'h17, 16'(i / 2));
            runTry(16'h2, i[0], i != 3 && i != 4, 1'b0);
        end
        wr(8'h17, 16'h0);
        for (i = 0; i < 8; i++) runTry(i[15:0], 1'b0, i < 3 || i == 5, i[0]);
        hoaStandardMode <= 1'b1;
        jogRequest <= 1'b1;
        runTry(16'h1, 1'b0, 1'b0, 1'b0);
        terminalFunc41Pin <= 1'b1;
        {keypadOptionPresent, handRequest} <= 2'h3;
        repeat (8) @(posedge core_clk);
        #1 chk("jog on", jogActive, 1'b1);
        chk("hand", handMode, 1'b1);
        wr(8'h15, 16'h0);
        {hoaStandardMode, jogRequest, handRequest} <= 3'h0;
        repeat (2) @(posedge core_clk);
        #1 chk("hand lock", handMode, 1'b1);
        $display("run test done");
        for (i = 0; i < 8; i++) begin
            v = i == 0 ? 16'h01a3 : i == 1 ? 16'h0244 : i == 2 ? 16'h0250 : $random(seed);
            wr(8'h19, v);
            #1 chk("places", decimalPlaces, places(v));
            chk("unit", displayUnit, unit(v));
        end
        for (j = 0; j < 3; j++) begin
            remoteFreqSource <= {3'h0, j[0]};
            freqCommand <= 16'h1000 + j[15:0];
            {faultEvent, undervoltagePin} <= {!j[1], j[1]};
            @(posedge core_clk) faultEvent <= 1'b0;
            repeat (6) @(posedge core_clk);
            rd(8'h18);
            chk("memory", rdv, 16'h1000 + {j[1], 1'b0});
        end
        wr(8'h1a, 16'h0);
        #1 chk("user off", userValueEnable, 1'b0);
        wr(8'h1a, 16'h0064);
        #1 chk("user on", userValueEnable, 1'b1);
        repeat (100) @(posedge core_clk);
        #1 chk("user", userValue, 16'(freqCommand * 32'd100 / maxOperatingFrequency));
        chk("valid", userValueValid, 1'b1);
        $display("display test done");
        give_verdict;
    end
endmodule : drive_command_display_config_test
`default_nettype wire
